// ---- src/spm_defines.svh ----
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

// apb register byte offsets
`define SPM_ADDR_W          12
`define SPM_OFF_CTRL        12'h000
`define SPM_OFF_STATUS      12'h004
`define SPM_OFF_MCAND       12'h008
`define SPM_OFF_PRODUCT     12'h00C

// control register fields
`define SPM_CTRL_SIGNED_BIT 0
`define SPM_CTRL_ADD_BIT    1
`define SPM_CTRL_W          2
`define SPM_CTRL_RESET      2'h2

// status register fields
`define SPM_STAT_CNT_LSB    0
`define SPM_STAT_CNT_W      8
`define SPM_STAT_STATE_LSB  8

// datapath widths
`define SPM_MCAND_W         8
`define SPM_CAPT_W          16

`endif

// ---- src/spm_pkg.sv ----
package spm_pkg;

  typedef enum logic [2:0]
  {
    SPM_IDLE = 3'b001,
    SPM_LOAD = 3'b010,
    SPM_RUN  = 3'b100
  } spm_state_e;

endpackage

// ---- src/spm_bitdelay.sv ----
module spm_bitdelay
  import spm_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] data_in,
  output logic      [W-1:0] data_out
);

  logic [W-1:0] hold_reg;
  logic [W-1:0] hold_next;

  always_comb
  begin
    hold_next = data_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_reg <= '0;
    else
      hold_reg <= hold_next;
  end

  assign data_out = hold_reg;

endmodule

// ---- src/spm_addsub.sv ----
module spm_addsub
  import spm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clear,
  input  wire logic add_sel,
  input  wire logic p_bit,
  input  wire logic b_bit,
  output logic      sum_out
);

  logic carry_reg;
  logic carry_next;
  logic sum_reg;
  logic sum_next;
  logic b_eff;

  // subtract adds the inverted addend with carry seeded to one
  always_comb
  begin
    b_eff = add_sel ? b_bit : ~b_bit;
    if (clear)
    begin
      carry_next = ~add_sel;
      sum_next   = 1'b0;
    end
    else
    begin
      sum_next   = p_bit ^ b_eff ^ carry_reg;
      carry_next = (p_bit & b_eff) | (p_bit & carry_reg) | (b_eff & carry_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      carry_reg <= 1'b0;
      sum_reg   <= 1'b0;
    end
    else
    begin
      carry_reg <= carry_next;
      sum_reg   <= sum_next;
    end
  end

  assign sum_out = sum_reg;

endmodule

// ---- src/spm_top.sv ----
// Behaviour
// RQ1: multiplicand word of 8 bits captured in parallel; multiplier bits arrive serially.
// RQ2: loading a multiplicand clears all arithmetic flip-flops to zero; the adder carry loads one in subtract mode instead.
// RQ3: driver presents one multiplier bit per rising clock edge throughout.
// RQ4: two's complement multiply; signed select decides multiplicand signed or unsigned.
// RQ5: cascade input wired to lsb serial output of next more significant slice.
// RQ6: two serial outputs: plain product and product plus or minus addend.
// RQ7: serial adder/subtractor after multiplier combines product with addend stream.
// RQ8: first cycle loads multiplicand and first multiplier bit; product invalid then.
// RQ9: delayed addend input passes one flip-flop, aligning with first valid product.
// RQ10: add select high adds, low subtracts, for every clocked bit.
// RQ11: controller pulses load strobe low, releases it before serial sequence.
`include "spm_defines.svh"

module spm_top
  import spm_pkg::*;
#(
  parameter int MW = `SPM_MCAND_W
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SPM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [MW-1:0]          multiplicand_in,
  input  wire logic                   load_strobe_n,
  input  wire logic                   multiplier_serial_in,
  input  wire logic                   cascade_in,
  input  wire logic                   addend_serial_in,
  input  wire logic                   delayed_addend_in,
  output logic                        product_serial_out,
  output logic                        sum_serial_out,
  output logic                        lsb_serial_out
);

  logic [`SPM_CTRL_W-1:0]     ctrl_reg;
  logic [`SPM_CTRL_W-1:0]     ctrl_next;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;
  logic                       err_reg;
  logic                       err_next;
  logic [MW-1:0]              mcand_reg;
  logic [MW-1:0]              mcand_next;
  logic [MW-1:0]              acc_reg;
  logic [MW-1:0]              acc_next;
  logic                       prod_reg;
  logic                       prod_next;
  logic [`SPM_STAT_CNT_W-1:0] cnt_reg;
  logic [`SPM_STAT_CNT_W-1:0] cnt_next;
  logic [`SPM_CAPT_W-1:0]     capt_reg;
  logic [`SPM_CAPT_W-1:0]     capt_next;
  spm_state_e                 state_reg;
  spm_state_e                 state_next;
  logic                       load;
  logic                       signed_mode;
  logic                       add_sel;
  logic                       mult_bit;
  logic                       addend_dly;
  logic                       addend_bit;
  logic [MW+1:0]              acc_ext;
  logic [MW+1:0]              pp_ext;
  logic [MW+1:0]              casc_ext;
  logic [MW+1:0]              cell_sum;
  logic [MW-1:0]              pp;
  logic                       setup;
  logic                       wr_en;
  logic                       hit;

  assign load        = ~load_strobe_n;  // [RQ11]
  assign signed_mode = ctrl_reg[`SPM_CTRL_SIGNED_BIT];
  assign add_sel     = ctrl_reg[`SPM_CTRL_ADD_BIT];

  // apb slave: zero wait states, read data registered in the setup cycle
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign hit   = (paddr == `SPM_OFF_CTRL) || (paddr == `SPM_OFF_STATUS) ||
                 (paddr == `SPM_OFF_MCAND) || (paddr == `SPM_OFF_PRODUCT);

  always_comb
  begin
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (wr_en && hit && paddr == `SPM_OFF_CTRL)
      ctrl_next = pwdata[`SPM_CTRL_W-1:0];
    if (setup)
    begin
      err_next   = ~hit;
      rdata_next = 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          `SPM_OFF_CTRL:
            rdata_next[`SPM_CTRL_W-1:0] = ctrl_reg;
          `SPM_OFF_STATUS:
          begin
            rdata_next[`SPM_STAT_CNT_LSB +: `SPM_STAT_CNT_W] = cnt_reg;
            rdata_next[`SPM_STAT_STATE_LSB +: 3] = state_reg;
          end
          `SPM_OFF_MCAND:
            rdata_next[MW-1:0] = mcand_reg;
          `SPM_OFF_PRODUCT:
            rdata_next[`SPM_CAPT_W-1:0] = capt_reg;
          default:
            rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg  <= `SPM_CTRL_RESET;
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & err_reg;

  // multiplier bit register, loaded on every edge including the load edge
  spm_bitdelay #(
    .W (1)
  ) u_mult_dly (
    .pclk     (pclk),
    .presetn  (presetn),
    .data_in  (multiplier_serial_in),  // [RQ3]
    .data_out (mult_bit)
  );

  // delayed addend: one extra clock so the load-edge bit meets product bit zero
  spm_bitdelay #(
    .W (1)
  ) u_addend_dly (
    .pclk     (pclk),
    .presetn  (presetn),
    .data_in  (delayed_addend_in),
    .data_out (addend_dly)  // [RQ9]
  );

  // arithmetic cells: partial sum plus gated multiplicand plus cascade bit
  always_comb
  begin
    pp       = mult_bit ? mcand_reg : '0;
    acc_ext  = signed_mode ? {{2{acc_reg[MW-1]}}, acc_reg} : {2'b00, acc_reg};  // [RQ4]
    pp_ext   = signed_mode ? {{2{pp[MW-1]}}, pp} : {2'b00, pp};  // [RQ4]
    casc_ext = {1'b0, cascade_in, {MW{1'b0}}};  // [RQ5]
    cell_sum = acc_ext + pp_ext + casc_ext;
    mcand_next = mcand_reg;
    if (load)
    begin
      mcand_next = multiplicand_in;  // [RQ1]
      acc_next   = '0;  // [RQ2]
      prod_next  = 1'b0;  // [RQ8]
    end
    else
    begin
      acc_next  = cell_sum[MW:1];
      prod_next = cell_sum[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mcand_reg <= '0;
      acc_reg   <= '0;
      prod_reg  <= 1'b0;
    end
    else
    begin
      mcand_reg <= mcand_next;
      acc_reg   <= acc_next;
      prod_reg  <= prod_next;
    end
  end

  assign product_serial_out = prod_reg;  // [RQ6]
  assign lsb_serial_out     = acc_reg[0];  // [RQ5]

  // direct and delayed addend share one adder; tie the unused one low
  assign addend_bit = addend_serial_in | addend_dly;

  spm_addsub u_addsub (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (load),  // [RQ2]
    .add_sel (add_sel),  // [RQ10]
    .p_bit   (prod_next),  // [RQ7]
    .b_bit   (addend_bit),
    .sum_out (sum_serial_out)  // [RQ6]
  );

  // sequence tracking, bit counter and product capture for software
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    capt_next  = capt_reg;
    case (state_reg)
      SPM_IDLE:
      begin
        if (load)
          state_next = SPM_LOAD;
      end
      SPM_LOAD:
      begin
        if (!load)
          state_next = SPM_RUN;
      end
      SPM_RUN:
      begin
        if (load)
          state_next = SPM_LOAD;
      end
      default:
        state_next = SPM_IDLE;
    endcase
    if (load)
    begin
      cnt_next  = '0;
      capt_next = '0;
    end
    else if (state_reg != SPM_IDLE)
    begin
      if (cnt_reg != {`SPM_STAT_CNT_W{1'b1}})
        cnt_next = cnt_reg + 1'b1;
      capt_next = {prod_next, capt_reg[`SPM_CAPT_W-1:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= SPM_IDLE;
      cnt_reg   <= '0;
      capt_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      capt_reg  <= capt_next;
    end
  end

endmodule

// ---- testbench/spm_feeder.sv ----
module spm_feeder
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [7:0]  x,
  input  wire logic [15:0] y,
  input  wire logic [15:0] b,
  output logic             load_strobe_n,
  output logic [7:0]       multiplicand_in,
  output logic             multiplier_serial_in,
  output logic             delayed_addend_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] n_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      n_reg <= 5'h10;
      {load_strobe_n, multiplicand_in, multiplier_serial_in, delayed_addend_in} <= 11'h400;
    end
    else if (start)
    begin
      load_strobe_n <= 1'b0;
      multiplicand_in <= x;
      multiplier_serial_in <= y[0];
      delayed_addend_in <= b[0];
      n_reg <= 5'h01;
    end
    else
    begin
      // lines not held once load or frame is over
      load_strobe_n <= 1'b1;
      multiplicand_in <= ~multiplicand_in;
      multiplier_serial_in <= n_reg[4] ? ~multiplier_serial_in : y[n_reg[3:0]];
      delayed_addend_in <= n_reg[4] ? ~delayed_addend_in : b[n_reg[3:0]];
      n_reg <= n_reg + {4'h0, !n_reg[4]};
    end
endmodule

// ---- testbench/spm_top_monitor.sv ----
module spm_top_monitor
#(
  parameter int MW = 8
)
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [MW-1:0] multiplicand_in,
  input wire logic          load_strobe_n,
  input wire logic          delayed_addend_in,
  input wire logic          product_serial_out,
  input wire logic          sum_serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       zero_reg;
  logic [1:0] ctrl_reg;
  logic       acc;
  assign acc = psel && penable;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // zero multiplicand loaded, and the mode word
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      zero_reg <= 1'b0;
      ctrl_reg <= 2'h2;
    end
    else
    begin
      if (!load_strobe_n)
        zero_reg <= multiplicand_in == '0;
      if (acc && pwrite && paddr == 12'h000)
        ctrl_reg <= pwdata[1:0];
    end
  property p_clr; !load_strobe_n |=> !product_serial_out; endproperty
  a_clr: assert property (p_clr) else $error("product not cleared");
  property p_sum0; !load_strobe_n |=> !sum_serial_out; endproperty
  a_sum0: assert property (p_sum0) else $error("sum valid too early");
  property p_zero; zero_reg |-> !product_serial_out; endproperty
  a_zero: assert property (p_zero) else $error("zero product wrong");
  property p_dly;
    zero_reg && ctrl_reg[1] && $past(load_strobe_n) && $past(load_strobe_n, 2)
      |-> sum_serial_out == $past(delayed_addend_in, 2);
  endproperty
  a_dly: assert property (p_dly) else $error("delayed addend wrong");
  property p_rdy; psel |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_bad; acc && paddr > 12'h00C |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_bad: assert property (p_bad) else $error("unmapped access");
  property p_good; acc && paddr <= 12'h00C |-> !pslverr; endproperty
  a_good: assert property (p_good) else $error("spurious error");
  property p_mode; acc && !pwrite && paddr == 12'h000 |-> prdata == {30'h0, ctrl_reg}; endproperty
  a_mode: assert property (p_mode) else $error("mode readback");
  c_load: cover property (!load_strobe_n);
  c_err: cover property (acc && pslverr);
  c_dly: cover property (zero_reg && ctrl_reg[1] && delayed_addend_in);
endmodule

bind spm_top spm_top_monitor #(.MW(MW)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .multiplicand_in, .load_strobe_n,
  .delayed_addend_in, .product_serial_out, .sum_serial_out);

// ---- testbench/test_serial_parallel_multiplier_addsub.sv ----
module test_serial_parallel_multiplier_addsub;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] c; logic [7:0] x; logic [15:0] y, b, p, s;} spm_row_s;
  // mode, multiplicand, multiplier, addend, product, product +/- addend
  spm_row_s rows [5] = '{
    '{2'h2, 8'h00, 16'h1234, 16'h0005, 16'h0000, 16'h0005},
    '{2'h2, 8'h0F, 16'h0003, 16'h0001, 16'h002D, 16'h002E},
    '{2'h0, 8'hFF, 16'h00FF, 16'h0001, 16'hFE01, 16'hFE00},
    '{2'h3, 8'hFE, 16'h0005, 16'h0010, 16'hFFF6, 16'h0006},
    '{2'h1, 8'h80, 16'hFFFF, 16'h0081, 16'h0080, 16'hFFFF}};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, start, er;
  logic        load_strobe_n, multiplier_serial_in, delayed_addend_in;
  logic        product_serial_out, sum_serial_out, lsb_serial_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  multiplicand_in, fx;
  logic [15:0] fy, fb, pv, sv;
  int          bad_count, cmp_count;
  spm_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .multiplicand_in, .load_strobe_n, .multiplier_serial_in, .delayed_addend_in,
    .cascade_in(1'b0), .addend_serial_in(1'b0), .product_serial_out, .sum_serial_out,
    .lsb_serial_out); // lone slice
  spm_feeder u_feed (.pclk, .presetn, .start, .x(fx), .y(fy), .b(fb), .load_strobe_n,
    .multiplicand_in, .multiplier_serial_in, .delayed_addend_in);
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict(input int late);
    bad_count += late;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 20);
    bad_count += int'(n == 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input spm_row_s r);
    logic lo;
    lo = 1'b0;
    apb(1'b1, 12'h000, {30'h0, r.c});
    fx <= r.x;
    fy <= r.y;
    fb <= r.b;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      #1;
      pv[i] = product_serial_out;
      sv[i] = sum_serial_out;
      lo = lo | lsb_serial_out;
    end
    // a zero multiplicand leaves the cascade tap silent
    if (r.x == 8'h00)
      chk(lo, 32'h0);
    chk(pv, r.p);
    chk(sv, r.s);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, {24'h0, r.x});
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[10:8], 32'h4);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial #40000 give_verdict(1);
  initial
  begin
    {presetn, psel, penable, pwrite, start, paddr, pwdata} = '0;
    {fx, fy, fb} = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[k])
    begin
      run(rows[k]);
      $display("row %0d done", k);
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({product_serial_out, sum_serial_out, lsb_serial_out}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h2);
    // idle state, counter cleared
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h100);
    $display("reset test done");
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk(er, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(er, 32'h1);
    $display("unmapped test done");
    give_verdict(0);
  end
endmodule
